// >>> shared/css_pkg.sv
// Constants, field positions and carrier types of the socket state block.
`default_nettype none
package css_pkg;
  // Register byte offsets on the Avalon bus.
  localparam logic [4:0] OFS_EVENT   = 5'h00;
  localparam logic [4:0] OFS_PRESENT = 5'h08;
  localparam logic [4:0] OFS_FORCE   = 5'h0c;
  localparam logic [4:0] OFS_CONTROL = 5'h10;
  localparam int         ADDR_W      = 5;
  localparam int         DATA_W      = 32;

  // Present-state and force field positions.
  localparam int B_ALT_Y_SUP  = 31;
  localparam int B_ALT_X_SUP  = 30;
  localparam int B_LOW_SUP    = 29;
  localparam int B_HIGH_SUP   = 28;
  localparam int B_VIDEO      = 27;
  localparam int B_RETEST     = 14;
  localparam int B_CARD_LOW   = 11;
  localparam int B_CARD_HIGH  = 10;
  localparam int B_BAD_REQ    = 9;
  localparam int B_LOST       = 8;
  localparam int B_UNKNOWN    = 7;
  localparam int B_CARD_IRQ   = 6;
  localparam int B_WIDE       = 5;
  localparam int B_NARROW     = 4;
  localparam int B_POWERED    = 3;
  localparam int B_CD2        = 2;
  localparam int B_CD1        = 1;
  localparam int B_STSCHG     = 0;

  // Event register field positions and width.
  localparam int EV_W         = 4;
  localparam int EV_POWER     = 3;
  localparam int EV_CD2       = 2;
  localparam int EV_CD1       = 1;
  localparam int EV_STSCHG    = 0;

  // Control register fields and supply request codes.
  localparam int VCC_LSB      = 4;
  localparam int VPP_LSB      = 0;
  localparam int SUP_W        = 3;
  localparam logic [2:0] VCC_OFF  = 3'h0;
  localparam logic [2:0] VCC_HIGH = 3'h2;
  localparam logic [2:0] VCC_LOW  = 3'h3;

  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // Bus answer phases, one-hot.
  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b01,
    BUS_ANSWER = 2'b10
  } css_bus_e;

  // Result of decoding card detect and voltage sense pins.
  typedef struct packed {
    logic unknown;
    logic wide;
    logic narrow;
    logic low_cap;
    logic high_cap;
  } css_detect_s;

  // Socket pins as seen by the block.
  typedef struct packed {
    logic cd1_n;
    logic cd2_n;
    logic vs1;
    logic vs2;
    logic irq_n;
    logic stschg;
  } css_pins_s;

  // Whole state of the block.
  typedef struct packed {
    css_bus_e          phase;
    logic [31:0]       rdata;
    logic [EV_W-1:0]   event_bits;
    logic              video;
    logic              block;
    logic              low_cap;
    logic              high_cap;
    logic              bad_req;
    logic              lost;
    logic              unknown;
    logic              wide;
    logic              narrow;
    logic              powered;
    logic [SUP_W-1:0]  vcc;
    logic [SUP_W-1:0]  vpp;
    logic              vcc_low_en;
    logic              vcc_high_en;
    logic [1:0]        cd_prev;
    logic              sts_prev;
    logic              present_prev;
  } css_state_s;
endpackage
`default_nettype wire

// >>> logic/css_socket_state.sv
// Socket present-state, event-force and power control register bank.
// Notes on behaviour
// - Alternative socket supply bits read zero.
// - Socket 3.3 V and 5 V bits read one.
// - Video flag zero at reset, force sets it.
// - Reserved and alternative card bits read zero.
// - Forced voltage flag blocks power-up until retest or a new card is seated.
// - Out-of-range supply request sets bad-request flag.
// - Removal while powered sets data-lost, write-one clears.
// - Unknown card sets flag, power withheld.
// - Card interrupt bit is inverted pin, unregistered.
// - Wide card detected sets its flag.
// - Narrow card flag disables voltage checking.
// - Powered flag updated on every power request.
// - Card detect bits mirror pin levels.
// - Lowest bit mirrors status-change pin.
// - Force register ones set event or state bits.
// - Retest force re-reads pins, unblocks power-up.
// - Card present: type force writes ignored.
// - Power and detect forces set only events.
// - Status-change force sets only its event.
// - Bad-request and data-lost forces set flags.
// - Reset clears control and removes power.
// - Never apply a supply the decode forbids, except to a narrow card.
// - Event bits write-one clear, reset zero.
`timescale 1ns/1ps
`default_nettype none
module css_socket_state #(
  parameter int ADDR_WIDTH = css_pkg::ADDR_W
) (
  input  wire logic                     clock,
  input  wire logic                     sys_rst,
  input  wire logic [ADDR_WIDTH-1:0]    avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  input  wire logic [3:0]               avs_byteenable,
  output logic [31:0]                   avs_readdata,
  output logic                          avs_waitrequest,
  input  wire logic                     card_cd1_n,
  input  wire logic                     card_cd2_n,
  input  wire logic                     card_vs1,
  input  wire logic                     card_vs2,
  input  wire logic                     card_irq_n,
  input  wire logic                     card_stschg,
  output logic                          vcc_low_en,
  output logic                          vcc_high_en,
  output logic [css_pkg::SUP_W-1:0]     vpp_select
);

  // The decoder only compares the low address bits it knows about.
  if (ADDR_WIDTH != css_pkg::ADDR_W)
  begin : g_bad_width
    $error("css_socket_state: ADDR_WIDTH must equal the package width.");
  end

  css_pkg::css_state_s s_q;
  css_pkg::css_state_s s_d;
  css_pkg::css_pins_s  pins;
  css_pkg::css_detect_s det;

  assign pins = '{cd1_n: card_cd1_n, cd2_n: card_cd2_n, vs1: card_vs1,
                  vs2: card_vs2, irq_n: card_irq_n, stschg: card_stschg};

  // Expands byte enables to a bit mask so that partial writes touch
  // only the lanes the master asked for, except a control write with lane 0 off, which loads zero vcc and vpp.
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // Card type decode of the detect and sense pins. A card seated on one
  // detect pin only cannot be trusted and is reported as unknown.
  function automatic css_pkg::css_detect_s decode_card(
    input css_pkg::css_pins_s p
  );
    decode_card = '0;
    if (p.cd1_n != p.cd2_n)
    begin
      decode_card.unknown = 1'b1;
    end
    else if (!p.cd1_n)
    begin
      case ({p.vs2, p.vs1})
        2'b11:
        begin
          decode_card.narrow   = 1'b1;
          decode_card.high_cap = 1'b1;
        end
        2'b10:
        begin
          decode_card.narrow   = 1'b1;
          decode_card.high_cap = 1'b1;
          decode_card.low_cap  = 1'b1;
        end
        2'b01:
        begin
          decode_card.wide     = 1'b1;
          decode_card.low_cap  = 1'b1;
        end
        default:
        begin
          decode_card.wide     = 1'b1;
          decode_card.low_cap  = 1'b1;
          decode_card.high_cap = 1'b1;
        end
      endcase
    end
  endfunction

  // Present-state word. The interrupt bit is taken from the pin in the
  // request cycle, so it lags the card by one clock in the answer.
  function automatic logic [31:0] present_word(
    input css_pkg::css_state_s st,
    input css_pkg::css_pins_s  p
  );
    present_word = css_pkg::ZERO_WORD;
    present_word[css_pkg::B_LOW_SUP]   = 1'b1;
    present_word[css_pkg::B_HIGH_SUP]  = 1'b1;
    present_word[css_pkg::B_VIDEO]     = st.video;
    present_word[css_pkg::B_CARD_LOW]  = st.low_cap;
    present_word[css_pkg::B_CARD_HIGH] = st.high_cap;
    present_word[css_pkg::B_BAD_REQ]   = st.bad_req;
    present_word[css_pkg::B_LOST]      = st.lost;
    present_word[css_pkg::B_UNKNOWN]   = st.unknown;
    present_word[css_pkg::B_CARD_IRQ]  = ~p.irq_n;
    present_word[css_pkg::B_WIDE]      = st.wide;
    present_word[css_pkg::B_NARROW]    = st.narrow;
    present_word[css_pkg::B_POWERED]   = st.powered;
    present_word[css_pkg::B_CD2]       = p.cd2_n;
    present_word[css_pkg::B_CD1]       = p.cd1_n;
    present_word[css_pkg::B_STSCHG]    = p.stschg;
  endfunction

  // Supply code check against the card capabilities. A narrow card skips
  // the check, so software carries the risk of a wrong code there.
  function automatic logic supply_in_range(
    input logic [css_pkg::SUP_W-1:0] code,
    input logic                      low_cap,
    input logic                      high_cap,
    input logic                      narrow
  );
    logic is_low;
    logic is_high;
    is_low          = (code == css_pkg::VCC_LOW);
    is_high         = (code == css_pkg::VCC_HIGH);
    supply_in_range = (is_low && low_cap) || (is_high && high_cap)
                   || ((is_low || is_high) && narrow);
  endfunction

  assign det = decode_card(pins);

  // Next-state logic: pin events first, then card detection, then the
  // bus. Hardware sets are applied after software clears so that an
  // event landing in the clearing cycle survives.
  always_comb
  begin
    logic        present;
    logic        commit;
    logic        do_wr;
    logic [31:0] wd;
    logic [css_pkg::EV_W-1:0] ev_set;
    logic        power_req;
    logic        permitted;
    logic        in_range;
    logic        retest;
    logic        removal;
    present   = !pins.cd1_n && !pins.cd2_n;
    commit    = (s_q.phase == css_pkg::BUS_ANSWER);
    do_wr     = commit && avs_write;
    wd        = avs_writedata & lane_mask(avs_byteenable);
    ev_set    = '0;
    power_req = 1'b0;
    permitted = 1'b0;
    in_range  = 1'b0;
    retest    = 1'b0;
    removal   = !present && s_q.present_prev;
    s_d       = s_q;

    // Pin history for change and assertion events. A card already seated
    // when reset lifts shows up as an insertion, since the history
    // restarts as an empty socket.
    s_d.cd_prev      = {pins.cd2_n, pins.cd1_n};
    s_d.sts_prev     = pins.stschg;
    s_d.present_prev = present;
    ev_set[css_pkg::EV_CD1] = pins.cd1_n != s_q.cd_prev[0];
    ev_set[css_pkg::EV_CD2] = pins.cd2_n != s_q.cd_prev[1];
    ev_set[css_pkg::EV_STSCHG] = pins.stschg && !s_q.sts_prev;

    // A new card: take its type and voltages, lift any forced block.
    if (present && !s_q.present_prev)
    begin
      s_d.unknown  = 1'b0;
      s_d.wide     = det.wide;
      s_d.narrow   = det.narrow;
      s_d.low_cap  = det.low_cap;
      s_d.high_cap = det.high_cap;
      s_d.block    = 1'b0;
    end
    else if (det.unknown)
    begin
      s_d.unknown = 1'b1;
      s_d.wide    = 1'b0;
      s_d.narrow  = 1'b0;
    end

    // Removal drops power; data still in flight may be gone.
    // This set wins over a clear written in the same cycle.
    if (removal)
    begin
      s_d.lost        = s_q.lost | s_q.powered;
      s_d.powered     = 1'b0;
      s_d.vcc_low_en  = 1'b0;
      s_d.vcc_high_en = 1'b0;
    end

    // Bus write side effects.
    if (do_wr && avs_address == css_pkg::OFS_EVENT)
    begin
      s_d.event_bits = s_q.event_bits & ~wd[css_pkg::EV_W-1:0];
    end
    if (do_wr && avs_address == css_pkg::OFS_PRESENT)
    begin
      if (wd[css_pkg::B_LOST])
      begin
        // A removal while powered in this very cycle keeps the flag set.
        s_d.lost = removal && s_q.powered;
      end
    end
    else if (do_wr && avs_address == css_pkg::OFS_FORCE)
    begin
      // Phantom register: ones set bits elsewhere, nothing is stored.
      if (wd[css_pkg::B_VIDEO])
      begin
        s_d.video = 1'b1;
      end
      if (wd[css_pkg::B_CARD_LOW] || wd[css_pkg::B_CARD_HIGH])
      begin
        s_d.low_cap  = s_q.low_cap | wd[css_pkg::B_CARD_LOW];
        s_d.high_cap = s_q.high_cap | wd[css_pkg::B_CARD_HIGH];
        s_d.block    = 1'b1;
      end
      if (wd[css_pkg::B_BAD_REQ])
      begin
        s_d.bad_req = 1'b1;
      end
      if (wd[css_pkg::B_LOST])
      begin
        s_d.lost = 1'b1;
      end
      if (!present)
      begin
        s_d.unknown = s_d.unknown | wd[css_pkg::B_UNKNOWN];
        s_d.wide    = s_d.wide | wd[css_pkg::B_WIDE];
        s_d.narrow  = s_d.narrow | wd[css_pkg::B_NARROW];
      end
      ev_set = ev_set | wd[css_pkg::EV_W-1:0];
      retest = wd[css_pkg::B_RETEST];
    end
    else if (do_wr && avs_address == css_pkg::OFS_CONTROL)
    begin
      s_d.vcc   = wd[css_pkg::VCC_LSB +: css_pkg::SUP_W];
      s_d.vpp   = wd[css_pkg::VPP_LSB +: css_pkg::SUP_W];
      power_req = 1'b1;
    end

    // Retest re-reads the sense pins, overriding forced voltage flags.
    if (retest)
    begin
      s_d.low_cap  = det.low_cap;
      s_d.high_cap = det.high_cap;
      s_d.block    = 1'b0;
    end

    // Supply request check against the capabilities now in force.
    in_range  = supply_in_range(s_d.vcc, s_d.low_cap, s_d.high_cap,
                                s_d.narrow);
    permitted = in_range && present && !s_d.block
             && !s_d.unknown;
    if (power_req)
    begin
      if (s_d.vcc == css_pkg::VCC_OFF)
      begin
        s_d.powered = 1'b0;
      end
      else
      begin
        s_d.powered = permitted;
        ev_set[css_pkg::EV_POWER] = permitted;
        if (!in_range)
        begin
          s_d.bad_req = 1'b1;
        end
      end
      s_d.vcc_low_en  = permitted && s_d.vcc == css_pkg::VCC_LOW;
      s_d.vcc_high_en = permitted && s_d.vcc == css_pkg::VCC_HIGH;
    end

    s_d.event_bits = s_d.event_bits | ev_set;

    // Bus answer: one wait cycle, read data loaded as waitrequest falls.
    // A request is seen only while idle, so the answer edge never starts
    // a second transfer from the same held request.
    case (s_q.phase)
      css_pkg::BUS_IDLE:
      begin
        s_d.rdata = css_pkg::ZERO_WORD;
        if (avs_read || avs_write)
        begin
          s_d.phase = css_pkg::BUS_ANSWER;
          if (avs_read && avs_address == css_pkg::OFS_EVENT)
          begin
            s_d.rdata[css_pkg::EV_W-1:0] = s_q.event_bits;
          end
          else if (avs_read && avs_address == css_pkg::OFS_PRESENT)
          begin
            s_d.rdata = present_word(s_q, pins);
          end
          else if (avs_read && avs_address == css_pkg::OFS_CONTROL)
          begin
            s_d.rdata[css_pkg::VCC_LSB +: css_pkg::SUP_W] = s_q.vcc;
            s_d.rdata[css_pkg::VPP_LSB +: css_pkg::SUP_W] = s_q.vpp;
          end
          else
          begin
            s_d.rdata = css_pkg::ZERO_WORD;
          end
        end
      end
      css_pkg::BUS_ANSWER:
      begin
        // Read data stand for the answer cycle only, then read as zero.
        s_d.phase = css_pkg::BUS_IDLE;
        s_d.rdata = css_pkg::ZERO_WORD;
      end
      default:
      begin
        s_d.phase = css_pkg::BUS_IDLE;
        s_d.rdata = css_pkg::ZERO_WORD;
      end
    endcase
  end

  // State register. Reset clears control and leaves the socket
  // unpowered; pin history restarts as if no card were seated.
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      s_q              <= '0;
      s_q.phase        <= css_pkg::BUS_IDLE;
      s_q.cd_prev      <= 2'h3;
      s_q.vcc          <= css_pkg::VCC_OFF;
      s_q.vcc_low_en   <= 1'b0;
      s_q.vcc_high_en  <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register. Waitrequest is the answer
  // phase bit seen from the other side, so it stays high during reset.
  assign avs_readdata    = s_q.rdata;
  assign avs_waitrequest = (s_q.phase != css_pkg::BUS_ANSWER);
  assign vcc_low_en      = s_q.vcc_low_en;
  assign vcc_high_en     = s_q.vcc_high_en;
  assign vpp_select      = s_q.vpp;

endmodule
`default_nettype wire

// >>> verification/css_socket_state_sva.sv
// Checker of bus timing, fixed present-state fields and supply enables.
`timescale 1ns/1ps
`default_nettype none
module css_socket_state_sva #(
  parameter int ADDR_WIDTH = css_pkg::ADDR_W
) (
  input wire logic                  clock,
  input wire logic                  sys_rst,
  input wire logic [ADDR_WIDTH-1:0] avs_address,
  input wire logic                  avs_read,
  input wire logic                  avs_write,
  input wire logic [31:0]           avs_writedata,
  input wire logic [3:0]            avs_byteenable,
  input wire logic [31:0]           avs_readdata,
  input wire logic                  avs_waitrequest,
  input wire logic                  card_cd1_n,
  input wire logic                  card_cd2_n,
  input wire logic                  card_vs1,
  input wire logic                  card_vs2,
  input wire logic                  card_irq_n,
  input wire logic                  card_stschg,
  input wire logic                  vcc_low_en,
  input wire logic                  vcc_high_en,
  input wire logic [2:0]            vpp_select
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  // Answer cycles of present-state and force reads.
  logic rd_ps;
  logic rd_fo;
  assign rd_ps = avs_read && !avs_waitrequest
                 && avs_address == ADDR_WIDTH'(css_pkg::OFS_PRESENT);
  assign rd_fo = avs_read && !avs_waitrequest
                 && avs_address == ADDR_WIDTH'(css_pkg::OFS_FORCE);

  property p_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("answer not after one wait");
  property p_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_one: assert property (p_one) else $error("answer longer than a cycle");
  property p_idle;
    avs_waitrequest |-> avs_readdata == 32'h0000_0000;
  endproperty
  a_idle: assert property (p_idle) else $error("read data outside answer");
  property p_alt;
    rd_ps |-> avs_readdata[31:30] == 2'h0;
  endproperty
  a_alt: assert property (p_alt) else $error("alt supply bits set");
  property p_sup;
    rd_ps |-> avs_readdata[29:28] == 2'h3;
  endproperty
  a_sup: assert property (p_sup) else $error("supply bits not one");
  property p_rsv;
    rd_ps |-> avs_readdata[26:12] == 15'h0000;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_irq;
    rd_ps |-> avs_readdata[6] == !$past(card_irq_n);
  endproperty
  a_irq: assert property (p_irq) else $error("card irq bit wrong");
  property p_force;
    rd_fo |-> avs_readdata == 32'h0000_0000;
  endproperty
  a_force: assert property (p_force) else $error("force reads nonzero");
  property p_sel;
    !(vcc_low_en && vcc_high_en);
  endproperty
  a_sel: assert property (p_sel) else $error("both supplies on");
  property p_seat;
    $rose(vcc_low_en || vcc_high_en) |-> !$past(card_cd1_n)
                                         && !$past(card_cd2_n);
  endproperty
  a_seat: assert property (p_seat) else $error("supply with no card");
  property p_rst;
    $fell(sys_rst) |-> !vcc_low_en && !vcc_high_en && vpp_select == 3'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("power kept over reset");
endmodule
`default_nettype wire

// >>> verification/css_card_model.sv
// Behavioural card seated in the socket, chosen by a kind code.
`timescale 1ns/1ps
`default_nettype none
module css_card_model (
  input  wire logic [2:0]        kind,
  input  wire logic              irq,
  input  wire logic              wake,
  output var css_pkg::css_pins_s pins
);
  // Kinds: 0 empty, 1 wide dual, 2 wide 3.3 V, 3 narrow 5 V, 4 broken.
  // Sense pins float high when empty, as the socket pull-ups leave them.
  always_comb
  begin
    pins.cd1_n  = kind == 3'h0;
    pins.cd2_n  = kind == 3'h0 || kind == 3'h4;
    pins.vs1    = kind != 3'h1;
    pins.vs2    = kind != 3'h1 && kind != 3'h2;
    pins.irq_n  = !(irq && kind != 3'h0);
    pins.stschg = wake && kind != 3'h0;
  end
endmodule
`default_nettype wire

// >>> verification/cardbus_socket_state_force_tb.sv
// Self-checking bench of the socket state and force register bank.
`timescale 1ns/1ps
`default_nettype none
module cardbus_socket_state_force_tb;
  logic               clock = 1'b0;
  logic               sys_rst = 1'b1;
  logic [4:0]         avs_address = 5'h00;
  logic               avs_read = 1'b0;
  logic               avs_write = 1'b0;
  logic [31:0]        avs_writedata = 32'h0000_0000;
  logic [31:0]        avs_readdata;
  logic               avs_waitrequest;
  logic               vcc_low_en;
  logic               vcc_high_en;
  logic [2:0]         vpp_select;
  logic [2:0]         kind = 3'h0;
  logic               irq = 1'b0;
  logic               wake = 1'b0;
  css_pkg::css_pins_s pins;
  int                 failures = 0;
  int                 total_checks = 0;

  // The 20 MHz clock.
  initial
  begin
    forever #25 clock = !clock;
  end

  css_socket_state i_dut (
    .clock(clock), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .card_cd1_n(pins.cd1_n), .card_cd2_n(pins.cd2_n),
    .card_vs1(pins.vs1), .card_vs2(pins.vs2), .card_irq_n(pins.irq_n),
    .card_stschg(pins.stschg), .vcc_low_en(vcc_low_en),
    .vcc_high_en(vcc_high_en), .vpp_select(vpp_select)
  );
  css_card_model i_card (.kind(kind), .irq(irq), .wake(wake), .pins(pins));

  task automatic complete_run();
    if (failures == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  // One bus cycle, held until waitrequest is seen low; a hang ends the run.
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clock);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0)
    begin
      failures++;
      complete_run();
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input string s, input logic [4:0] a,
                     input logic [31:0] m, e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(s, e, q & m);
  endtask
  task automatic ps(input logic [31:0] m, e);
    rdc("present", css_pkg::OFS_PRESENT, m, e);
  endtask
  task automatic ev(input logic [31:0] e);
    rdc("event", css_pkg::OFS_EVENT, 32'hffff_ffff, e);
  endtask
  task automatic ctl(input logic [31:0] d);
    wr(css_pkg::OFS_CONTROL, d);
  endtask
  task automatic frc(input logic [31:0] d);
    wr(css_pkg::OFS_FORCE, d);
  endtask
  // Supply enables are looked at mid-cycle, after the commit edge settles.
  task automatic pw(input logic [1:0] e);
    @(negedge clock);
    chk("vcc", {30'h0, e}, {30'h0, vcc_high_en, vcc_low_en});
  endtask
  // Pin events latch one edge late, so a few edges pass before reading.
  task automatic settle();
    repeat (4) @(posedge clock);
  endtask
  task automatic put(input logic [2:0] k, input logic i, w);
    @(posedge clock);
    kind <= k;
    irq <= i;
    wake <= w;
    settle();
  endtask
  task automatic do_reset(input int n);
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (n) @(posedge clock);
    sys_rst <= 1'b0;
    settle();
  endtask

  task automatic t_reset_vals();
    ps(32'hffff_ffff, 32'h3000_0006);
    ev(32'h0000_0000);
    rdc("force", css_pkg::OFS_FORCE, 32'hffff_ffff, 32'h0);
    rdc("control", css_pkg::OFS_CONTROL, 32'hffff_ffff, 32'h0);
    wr(5'h04, 32'hffff_ffff);
    rdc("unmapped", 5'h04, 32'hffff_ffff, 32'h0);
  endtask

  task automatic t_force_all();
    frc(32'hffff_bfff);
    ps(32'hffff_ffff, 32'h3800_0fb6);
    ev(32'h0000_000f);
    wr(css_pkg::OFS_EVENT, 32'h0000_000f);
    ev(32'h0000_0000);
    wr(css_pkg::OFS_PRESENT, 32'h0000_0100);
    ps(32'hffff_ffff, 32'h3800_0eb6);
    do_reset(2);
    ps(32'hffff_ffff, 32'h3000_0006);
  endtask

  task automatic t_wide_card();
    put(3'h1, 1'b0, 1'b0);
    ev(32'h0000_0006);
    ps(32'hffff_ffff, 32'h3000_0c20);
    wr(css_pkg::OFS_EVENT, 32'h0000_000f);
    ctl(32'h0000_0032);
    pw(2'b01);
    chk("vpp", 32'h2, {29'h0, vpp_select});
    ps(32'hffff_ffff, 32'h3000_0c28);
    ev(32'h0000_0008);
    rdc("control", css_pkg::OFS_CONTROL, 32'hffff_ffff, 32'h32);
    put(3'h1, 1'b1, 1'b1);
    ps(32'hffff_ffff, 32'h3000_0c69);
    ev(32'h0000_0009);
    wr(css_pkg::OFS_EVENT, 32'h0000_000f);
    frc(32'h0000_00b7);
    ev(32'h0000_0007);
    ps(32'hffff_ffff, 32'h3000_0c69);
    put(3'h0, 1'b0, 1'b0);
    pw(2'b00);
    ps(32'h0000_010f, 32'h0000_0106);
    wr(css_pkg::OFS_PRESENT, 32'h0000_0100);
    ps(32'h0000_0100, 32'h0000_0000);
  endtask

  task automatic t_bad_block();
    put(3'h2, 1'b0, 1'b0);
    do_reset(2);
    ps(32'hffff_ffff, 32'h3000_0820);
    ctl(32'h0000_0020);
    pw(2'b00);
    ps(32'h0000_0208, 32'h0000_0200);
    frc(32'h0000_0400);
    ctl(32'h0000_0030);
    pw(2'b00);
    ps(32'h0000_0c00, 32'h0000_0c00);
    frc(32'h0000_4000);
    ps(32'h0000_0c00, 32'h0000_0800);
    ctl(32'h0000_0030);
    pw(2'b01);
    do_reset(2);
    pw(2'b00);
    rdc("control", css_pkg::OFS_CONTROL, 32'hffff_ffff, 32'h0);
  endtask

  task automatic t_unknown();
    put(3'h4, 1'b0, 1'b0);
    do_reset(2);
    ps(32'h0000_0080, 32'h0000_0080);
    ctl(32'h0000_0030);
    pw(2'b00);
  endtask

  task automatic t_narrow();
    put(3'h3, 1'b0, 1'b0);
    do_reset(2);
    ps(32'hffff_ffff, 32'h3000_0410);
    ctl(32'h0000_0020);
    pw(2'b10);
    ps(32'h0000_0008, 32'h0000_0008);
    ctl(32'h0000_0000);
    pw(2'b00);
    ps(32'h0000_0008, 32'h0000_0000);
  endtask

  // Main sequence.
  initial
  begin
    do_reset(16);
    t_reset_vals();
    t_force_all();
    t_wide_card();
    t_bad_block();
    t_unknown();
    t_narrow();
    complete_run();
  end
endmodule

bind css_socket_state css_socket_state_sva #(.ADDR_WIDTH(ADDR_WIDTH)) i_sva (
  .clock(clock), .sys_rst(sys_rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .card_cd1_n(card_cd1_n), .card_cd2_n(card_cd2_n),
  .card_vs1(card_vs1), .card_vs2(card_vs2), .card_irq_n(card_irq_n),
  .card_stschg(card_stschg), .vcc_low_en(vcc_low_en),
  .vcc_high_en(vcc_high_en), .vpp_select(vpp_select)
);
`default_nettype wire
